// ---- frd_pkg.sv ----
// shared constants and carrier types for the fault retry and diagnostics block
package frd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned FRD_CLK_NS = 25; // system clock period in ns
	localparam int unsigned FRD_TICK_NS = 1000000; // one millisecond tick, in ns
	// cycles per ms tick, rounded up
	localparam int unsigned FRD_TICK_CYC = (FRD_TICK_NS + FRD_CLK_NS - 1) / FRD_CLK_NS;
	localparam int unsigned FRD_LOW_CUR_CHECK_MS = 150; // low sense ratio check interval
	localparam int unsigned FRD_RETRY_STEP_MS = 16; // retry period per step of the field

	////////////////////////////////////////////////////////////////////////////////
	// widths and counter values
	localparam int FRD_NCH = 2; // channels
	localparam int FRD_CNT_W = 4; // retry counter width
	localparam int FRD_MS_W = 8; // millisecond timer width
	localparam logic [3:0] FRD_CNT_MAX = 4'hf; // retry budget
	localparam logic [3:0] FRD_CNT_RST = 4'h0; // counter after reset or clear
	localparam logic FRD_PIN_RST = 1'b1; // fault pin released after reset

	////////////////////////////////////////////////////////////////////////////////
	// retry state, one-hot
	typedef enum logic [3:0] {
		FRD_NORMAL = 4'h1, // channel follows its request
		FRD_WAIT_CAUSE = 4'h2, // off, waiting for temperature or supply to recover
		FRD_RETRY_WAIT = 4'h4, // off, timing the retry period
		FRD_LATCHED = 4'h8 // off until delatched
	} frd_retry_st_t;

	// per-channel configuration bits
	typedef struct packed {
		logic load_type_select; // 0 lamp, 1 motor
		logic retry_select; // retry select bit D0
		logic retry_endless; // endless retry bit D1
		logic [1:0] retry_period; // retry period field D3:D2
		logic direct_input_disable; // D5
		logic supply_short_disable; // D6
		logic open_load_dark_disable; // D7
		logic open_load_lit_disable; // D8
		logic low_sense_ratio; // 1 low ratio, 0 high ratio
		logic internal_pwm; // 1 internal pwm, 0 direct input
		logic fast_slew; // fast slew rate selected
	} frd_chan_cfg_t;

	// per-channel events and detector levels
	typedef struct packed {
		logic fault_control; // channel fault control signal
		logic overcurrent; // over-current fault
		logic short_circuit; // severe short-circuit fault
		logic overtemp; // over-temperature fault
		logic switch_request; // channel commanded on
		logic delatch; // delatch sequence, pulse
		logic fault_word_read; // fault word read, pulse
		logic turn_off; // turn-off instant, pulse
		logic oc_free_period_end; // turn-off of a pwm period without over-current, pulse
		logic open_load_lit_raw; // load current below the on-state threshold
		logic open_load_dark_raw; // off-state output above open-load threshold
		logic supply_short_raw; // off-state output above short threshold
	} frd_chan_in_t;

	// per-channel results, all registered
	typedef struct packed {
		logic chan_on; // switch the channel on
		logic retry_active; // channel off inside a retry cycle
		logic latched; // channel latched off
		logic retry_fault; // latchable fault bit
		logic budget_spent; // status word budget flag
		logic open_load_lit; // fault word bit
		logic open_load_dark; // fault word bit
		logic short_to_supply; // fault word bit
		logic oc_duration_clear; // clear the over-current duration counter, pulse
		logic [3:0] reattempt_readback; // retry counter, normal mode only
	} frd_chan_out_t;

endpackage

// ---- frd_tick_div.sv ----
// divider that makes a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module frd_tick_div #(
	parameter int unsigned DIV = 40000
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// enable pulse
	output logic o_tick
);
	import frd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// refuse a divider the counter cannot serve
	if (DIV < 2 || DIV > 32'h00ffffff) begin : g_bad_div
		$error("frd_tick_div: DIV out of range");
	end

	typedef struct packed {
		logic [23:0] cnt; // cycles since last tick
		logic tick; // registered pulse
	} frd_div_state_t;

	frd_div_state_t q; // registered state
	frd_div_state_t d; // next state

	// count up and wrap, pulsing at the wrap
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt == 24'(DIV - 1)) begin
			d.cnt = 24'h000000;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 24'h000001;
		end
	end

	// state register
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_tick = q.tick;
endmodule

// ---- frd_fault_retry.sv ----
// per-channel auto-retry and load diagnostics for a two-channel high side switch
`timescale 1ns/1ps
// Notes on behaviour
// - retry enabled when select bit equals load type
// - fault with control set starts retry, reenable
// - retry period timed from two-bit period field
// - cause gone: normal, pin high, counter kept
// - endless mode with retry enabled retries forever, never latches
// - limited: four-bit count to fifteen, budget flag
// - spent budget: one retry more, then latch
// - delatch turns channel on, counter unchanged
// - counter readback only in normal mode
// - counter cleared by listed events
// - endless select delatches latched channel
// - duration counter clear per load profile
// - diagnostic faults flag only, each disableable
// - off-state supply short, live pin, sticky
// - off-state open load, pin live, sticky
// - on-state open load pulls pin, bit sticky
// - high ratio read clears per on/off state
// - low ratio internal pwm: periodic check
// - low ratio direct input: check each turn-off
// - low ratio clear needs prior clean check
// - retry cause: overcurrent, short, heat, undervoltage
// - heat and undervoltage retry after cause gone
module frd_fault_retry
	import frd_pkg::*;
#(
	parameter int NCH = FRD_NCH,
	parameter int unsigned TICK_CYC = FRD_TICK_CYC,
	parameter int unsigned LOW_CUR_CHECK_MS = FRD_LOW_CUR_CHECK_MS,
	parameter int unsigned RETRY_STEP_MS = FRD_RETRY_STEP_MS
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// per-channel configuration and events
	input frd_pkg::frd_chan_cfg_t [NCH-1:0] i_cfg,
	input frd_pkg::frd_chan_in_t [NCH-1:0] i_chan,
	// device-wide conditions
	input wire logic i_undervoltage,
	input wire logic i_failsafe_entry,
	input wire logic i_sleep_exit,
	input wire logic i_normal_mode,
	// results
	output frd_pkg::frd_chan_out_t [NCH-1:0] o_chan,
	output logic o_fault_pin_n
);
	import frd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks
	if (NCH < 1 || NCH > 8) begin : g_bad_nch
		$error("frd_fault_retry: NCH out of range");
	end
	if (RETRY_STEP_MS < 1 || RETRY_STEP_MS > 63) begin : g_bad_step
		$error("frd_fault_retry: RETRY_STEP_MS out of range");
	end
	if (LOW_CUR_CHECK_MS < 1 || LOW_CUR_CHECK_MS > 254) begin : g_bad_chk
		$error("frd_fault_retry: LOW_CUR_CHECK_MS out of range");
	end

	localparam logic [FRD_MS_W-1:0] CHK_MS = FRD_MS_W'(LOW_CUR_CHECK_MS);
	localparam logic [FRD_MS_W-1:0] STEP_MS = FRD_MS_W'(RETRY_STEP_MS);

	////////////////////////////////////////////////////////////////////////////////
	// state types
	typedef struct packed {
		frd_retry_st_t st; // retry state
		logic [FRD_CNT_W-1:0] cnt; // retry counter
		logic spent; // budget used up
		logic final_used; // the extra retry after the budget was taken
		logic [FRD_MS_W-1:0] ms; // retry period timer, saturating
		logic [FRD_MS_W-1:0] ol_ms; // time since last low ratio check, saturating
		logic lit_live; // on-state open load currently present
		logic clean_seen; // the latest low ratio check found no fault, not cleared since
		logic motor_pend; // motor profile awaits an over-current free period
		logic sel_q; // last retry select bit
		frd_chan_out_t out; // registered outputs
	} frd_chan_state_t;

	typedef struct packed {
		frd_chan_state_t [NCH-1:0] ch; // channels
		logic pin_n; // fault pin, active low
	} frd_state_t;

	frd_state_t q; // registered state
	frd_state_t d; // next state
	logic tick; // one ms enable

	////////////////////////////////////////////////////////////////////////////////
	// millisecond time base, shared by both channels
	frd_tick_div #(
		.DIV(TICK_CYC)
	) u_tick (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.o_tick(tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next state for all channels
	always_comb begin
		frd_chan_state_t s; // working copy of one channel
		frd_chan_cfg_t cfg; // its configuration
		frd_chan_in_t in; // its events
		logic en; // auto-retry enabled
		logic cause; // retry condition
		logic slow_cause; // temperature or supply cause
		logic [FRD_MS_W-1:0] per; // retry period in ms
		logic on_now; // channel currently on
		logic ss_live; // supply short present now
		logic dark_live; // off-state open load present now
		logic chk; // low ratio check event
		logic lit_set; // on-state open load to be stored
		logic pin_low; // any channel pulls the fault pin
		s = '0;
		cfg = '0;
		in = '0;
		en = 1'b0;
		cause = 1'b0;
		slow_cause = 1'b0;
		per = '0;
		on_now = 1'b0;
		ss_live = 1'b0;
		dark_live = 1'b0;
		chk = 1'b0;
		lit_set = 1'b0;
		pin_low = 1'b0;
		d = q;
		// one pass per channel; the channels share only the time base, the device-wide conditions and the pin
		for (int c = 0; c < NCH; c++) begin
			s = q.ch[c];
			cfg = i_cfg[c];
			in = i_chan[c];
			on_now = q.ch[c].out.chan_on;
			en = (cfg.retry_select == cfg.load_type_select);
			cause = in.overcurrent | in.short_circuit | in.overtemp | i_undervoltage;
			slow_cause = in.overtemp | i_undervoltage;
			per = FRD_MS_W'((8'(cfg.retry_period) + 8'h01) * STEP_MS);
			s.out.oc_duration_clear = 1'b0;
			// timers advance on the ms tick and stop at full scale
			if (tick && s.ms != '1) begin
				s.ms = s.ms + 8'h01;
			end
			if (tick && s.ol_ms != '1) begin
				s.ol_ms = s.ol_ms + 8'h01;
			end
			// a read clears the retry fault bit unless a new fault sets it below
			if (in.fault_word_read) begin
				s.out.retry_fault = 1'b0;
			end
			// retry state machine
			if (in.delatch && s.st != FRD_NORMAL) begin
				s.st = FRD_NORMAL;
			end else begin
				case (s.st)
					FRD_NORMAL: begin
						// a fault that clears itself leaves the count and bit alone
						if (in.fault_control && cause) begin
							s.out.retry_fault = 1'b1;
							if (!en) begin
								s.st = FRD_LATCHED;
							end else if (!cfg.retry_endless && s.spent && s.final_used) begin
								s.st = FRD_LATCHED;
							end else if (slow_cause) begin
								s.st = FRD_WAIT_CAUSE;
							end else begin
								s.st = FRD_RETRY_WAIT;
								s.ms = '0;
							end
						end
					end
					FRD_WAIT_CAUSE: begin
						// period timing starts only once the slow cause has gone
						if (!slow_cause) begin
							s.st = FRD_RETRY_WAIT;
							s.ms = '0;
						end
					end
					FRD_RETRY_WAIT: begin
						if (s.ms >= per) begin
							s.st = FRD_NORMAL;
							if (!cfg.load_type_select) begin
								s.out.oc_duration_clear = 1'b1;
							end else begin
								s.motor_pend = 1'b1;
							end
							if (!cfg.retry_endless) begin
								if (s.spent) begin
									s.final_used = 1'b1;
								end else if (s.cnt != FRD_CNT_MAX) begin
									s.cnt = s.cnt + 4'h1;
									s.spent = (s.cnt == FRD_CNT_MAX);
								end
							end
						end
					end
					FRD_LATCHED: begin
						// held off until a delatch or an endless selection
						s.st = FRD_LATCHED;
					end
					default: begin
						s.st = FRD_NORMAL;
					end
				endcase
			end
			// motor profile clears duration at the first clean period after a retry
			if (cfg.load_type_select && s.motor_pend && in.oc_free_period_end) begin
				s.out.oc_duration_clear = 1'b1;
				s.motor_pend = 1'b0;
			end
			// selecting endless mode releases a latched channel
			if (cfg.retry_endless && q.ch[c].st == FRD_LATCHED && !in.delatch) begin
				s.st = en ? FRD_RETRY_WAIT : FRD_NORMAL;
				s.ms = '0;
			end
			// counter clear events; power-on is the reset itself
			if (i_failsafe_entry || i_sleep_exit || cfg.retry_endless
					|| (cfg.retry_select != q.ch[c].sel_q && !en)) begin
				s.cnt = FRD_CNT_RST;
				s.spent = 1'b0;
				s.final_used = 1'b0;
			end
			s.sel_q = cfg.retry_select;
			// off-state checks, reported live and stored
			ss_live = !on_now && in.supply_short_raw && !cfg.supply_short_disable;
			dark_live = !on_now && in.open_load_dark_raw && !cfg.open_load_dark_disable;
			// on-state open load, continuous or at check events by sense ratio
			chk = 1'b0;
			lit_set = 1'b0;
			if (cfg.open_load_lit_disable) begin
				s.lit_live = 1'b0;
			end else if (!cfg.low_sense_ratio) begin
				s.lit_live = on_now && in.open_load_lit_raw;
				lit_set = s.lit_live;
			end else begin
				if (in.turn_off && cfg.fast_slew) begin
					if (cfg.internal_pwm) begin
						chk = (q.ch[c].ol_ms >= CHK_MS);
					end else begin
						chk = !cfg.direct_input_disable;
					end
				end
				if (chk) begin
					s.lit_live = in.open_load_lit_raw;
					lit_set = in.open_load_lit_raw;
					s.ol_ms = '0;
				end
			end
			// clearing read first, so that a set in the same cycle wins
			if (in.fault_word_read) begin
				s.out.short_to_supply = 1'b0;
				s.out.open_load_dark = 1'b0;
				if (!cfg.low_sense_ratio) begin
					if (!on_now || !in.open_load_lit_raw) begin
						s.out.open_load_lit = 1'b0;
					end
				end else if (s.clean_seen) begin
					s.out.open_load_lit = 1'b0;
					s.clean_seen = 1'b0;
				end
			end
			if (chk) begin
				s.clean_seen = !in.open_load_lit_raw;
			end
			if (ss_live) begin
				s.out.short_to_supply = 1'b1;
			end
			if (dark_live) begin
				s.out.open_load_dark = 1'b1;
			end
			if (lit_set) begin
				s.out.open_load_lit = 1'b1;
			end
			// outputs from the new state; diagnostics never switch the channel off
			s.out.chan_on = (s.st == FRD_NORMAL) && in.switch_request;
			s.out.retry_active = (s.st == FRD_WAIT_CAUSE) || (s.st == FRD_RETRY_WAIT);
			s.out.latched = (s.st == FRD_LATCHED);
			s.out.budget_spent = s.spent;
			s.out.reattempt_readback = i_normal_mode ? s.cnt : FRD_CNT_RST;
			// pin follows live conditions; a recovered channel releases it
			pin_low = pin_low | (s.st != FRD_NORMAL) | ss_live | dark_live | s.lit_live;
			d.ch[c] = s;
		end
		d.pin_n = ~pin_low;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register with synchronous reset, which also stands for power-on
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			q <= '0;
			q.pin_n <= FRD_PIN_RST;
			for (int c = 0; c < NCH; c++) begin
				q.ch[c].st <= FRD_NORMAL;
			end
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			o_chan[c] = q.ch[c].out;
		end
	end
	assign o_fault_pin_n = q.pin_n;
endmodule

// ---- frd_fault_retry_assertions.sv ----
// concurrent checks on the ports of the fault retry and diagnostics block
`timescale 1ns/1ps
module frd_fault_retry_assertions
	import frd_pkg::*;
#(
	parameter int NCH = FRD_NCH
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// watched inputs
	input frd_pkg::frd_chan_cfg_t [NCH-1:0] i_cfg,
	input frd_pkg::frd_chan_in_t [NCH-1:0] i_chan,
	input wire logic i_undervoltage,
	input wire logic i_failsafe_entry,
	input wire logic i_sleep_exit,
	input wire logic i_normal_mode,
	// watched outputs
	input frd_pkg::frd_chan_out_t [NCH-1:0] o_chan,
	input wire logic o_fault_pin_n
);
	import frd_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////////////////
	// retry control, channel 0 stands for both
	chk_retry_keeps_off: assert property (o_chan[0].retry_active |-> !o_chan[0].chan_on)
		else $error("channel on during retry wait");
	chk_latch_pulls_pin: assert property (
		o_chan[0].latched && $past(o_chan[0].latched) |-> !o_fault_pin_n)
		else $error("pin high while latched");
	chk_endless_no_latch: assert property (i_cfg[0].retry_endless |=> !o_chan[0].latched)
		else $error("latched while endless");
	chk_endless_clears_count: assert property (
		i_cfg[0].retry_endless [*2] |=> o_chan[0].reattempt_readback == 4'h0)
		else $error("count kept in endless");
	chk_mode_clears_count: assert property (
		(i_failsafe_entry || i_sleep_exit) |=> o_chan[0].reattempt_readback == 4'h0)
		else $error("count not cleared");
	chk_delatch_releases: assert property (
		o_chan[0].latched && i_chan[0].delatch |=> !o_chan[0].latched)
		else $error("delatch ignored");
	chk_readback_gated: assert property (
		!i_normal_mode |=> o_chan[0].reattempt_readback == 4'h0)
		else $error("readback outside normal mode");
	////////////////////////////////////////////////////////////////////////////////
	// diagnostic bits are sticky until a read, and a disabled check never sets
	chk_short_sticky: assert property (
		o_chan[0].short_to_supply && !i_chan[0].fault_word_read |=> o_chan[0].short_to_supply)
		else $error("short bit lost");
	chk_dark_sticky: assert property (
		o_chan[0].open_load_dark && !i_chan[0].fault_word_read |=> o_chan[0].open_load_dark)
		else $error("dark bit lost");
	chk_lit_sticky: assert property (
		o_chan[0].open_load_lit && !i_chan[0].fault_word_read |=> o_chan[0].open_load_lit)
		else $error("lit bit lost");
	chk_short_sets: assert property (
		i_chan[0].supply_short_raw && !o_chan[0].chan_on && !i_cfg[0].supply_short_disable
		|=> o_chan[0].short_to_supply) else $error("short not flagged");
	chk_lit_disabled: assert property (
		i_cfg[0].open_load_lit_disable && !o_chan[0].open_load_lit |=> !o_chan[0].open_load_lit)
		else $error("disabled check set bit");
	// main scenarios reached
	cov_latched: cover property (o_chan[0].latched);
	cov_budget: cover property (o_chan[0].budget_spent);
	cov_retry_done: cover property ($fell(o_chan[0].retry_active));
	cov_motor_clear: cover property (o_chan[0].oc_duration_clear && i_cfg[0].load_type_select);
endmodule
bind frd_fault_retry frd_fault_retry_assertions #(.NCH(NCH)) i_chk (.i_clk_sys(i_clk_sys),
	.i_rst(i_rst), .i_cfg(i_cfg), .i_chan(i_chan), .i_undervoltage(i_undervoltage),
	.i_failsafe_entry(i_failsafe_entry), .i_sleep_exit(i_sleep_exit),
	.i_normal_mode(i_normal_mode), .o_chan(o_chan), .o_fault_pin_n(o_fault_pin_n));

// ---- frd_host_model.sv ----
// host model: turns a read request into one fault word read strobe
`timescale 1ns/1ps
module frd_host_model (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// request from the sequence
	input wire logic i_rd_req,
	// strobe towards the device
	output logic o_fault_word_read
);
	logic req_q; // request seen last cycle
	////////////////////////////////////////////////////////////////////////////////
	// one strobe per rising request, so a held request never reads twice
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			req_q <= 1'b0;
			o_fault_word_read <= 1'b0;
		end else begin
			req_q <= i_rd_req;
			o_fault_word_read <= i_rd_req & ~req_q;
		end
	end
endmodule

// ---- frd_fault_retry_tb_top.sv ----
// self-checking bench for the fault retry and diagnostics block
`timescale 1ns/1ps
module frd_fault_retry_tb_top;
	import frd_pkg::*;
	localparam int TK = 4; // cycles per ms tick, shortened
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	frd_chan_cfg_t [1:0] cfg = '0; // lamp, select 0, direct input never pulsed
	frd_chan_in_t [1:0] ch = '0;
	frd_chan_in_t [1:0] ch_w; // ch with the host read strobe merged
	frd_chan_out_t [1:0] oc;
	logic pin_n, rd, rd_req = 1'b0, uv = 1'b0, fs = 1'b0, se = 1'b0, nm = 1'b1;
	int err_count = 0;
	int checked = 0;
	int clr_cnt = 0; // duration clear pulses seen
	int n;
	always #12.5 i_clk_sys = ~i_clk_sys;
	always_comb begin
		ch_w = ch;
		ch_w[0].fault_word_read = rd;
	end
	// count duration clear pulses as they stand
	always @(posedge i_clk_sys) clr_cnt <= clr_cnt + int'(oc[0].oc_duration_clear === 1'b1);
	frd_fault_retry #(.TICK_CYC(TK), .LOW_CUR_CHECK_MS(3), .RETRY_STEP_MS(1)) i_dut (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cfg(cfg), .i_chan(ch_w),
		.i_undervoltage(uv), .i_failsafe_entry(fs), .i_sleep_exit(se), .i_normal_mode(nm),
		.o_chan(oc), .o_fault_pin_n(pin_n));
	frd_host_model i_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rd_req(rd_req),
		.o_fault_word_read(rd));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm_s, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm_s, exp, seen);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge i_clk_sys);
		#1;
	endtask
	// one-cycle overcurrent fault with fault control set, sampled just after it lands
	task automatic fault();
		@(posedge i_clk_sys);
		ch[0].fault_control <= 1'b1;
		ch[0].overcurrent <= 1'b1;
		@(posedge i_clk_sys);
		ch[0].fault_control <= 1'b0;
		ch[0].overcurrent <= 1'b0;
		#1;
	endtask
	// host read of the fault word; the strobe lands two edges later
	task automatic read();
		@(posedge i_clk_sys);
		rd_req <= 1'b1;
		@(posedge i_clk_sys);
		rd_req <= 1'b0;
		tick(3);
	endtask
	// one turn-off instant, sampled one edge after it lands
	task automatic toff();
		@(posedge i_clk_sys);
		ch[0].turn_off <= 1'b1;
		@(posedge i_clk_sys);
		ch[0].turn_off <= 1'b0;
		tick(1);
	endtask
	// bounded wait for the retry wait to end
	task automatic wait_idle(output int k);
		k = 0;
		while (oc[0].retry_active !== 1'b0 && k < 200) begin
			tick(1);
			k++;
		end
		if (k == 200) begin
			err_count++;
			conclude();
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		tick(1);
		chk("reset pin", pin_n, 8'h1);
		chk("reset count", oc[0].reattempt_readback, 8'h0);
		ch[0].switch_request <= 1'b1;
		// limited retries over every period code, then the last retry and the latch
		for (int i = 1; i <= 17; i++) begin
			cfg[0].retry_period <= 2'(i % 4);
			fault();
			if (i == 17) break;
			chk("retry off", {oc[0].retry_active, oc[0].chan_on, pin_n}, 8'h4);
			wait_idle(n);
			chk("period", 8'(n >= (i % 4) * TK && n <= (i % 4 + 1) * TK + 2), 8'h1);
			tick(2);
			chk("back on", {oc[0].chan_on, pin_n, oc[0].retry_fault}, 8'h7);
			chk("count", oc[0].reattempt_readback, 8'(i > 15 ? 15 : i));
			chk("budget", oc[0].budget_spent, 8'(i >= 15));
		end
		tick(1);
		chk("latched", {oc[0].latched, oc[0].chan_on, pin_n}, 8'h4);
		nm <= 1'b0;
		tick(2);
		chk("readback gated", oc[0].reattempt_readback, 8'h0);
		nm <= 1'b1;
		cfg[0].retry_endless <= 1'b1;
		tick(3);
		chk("endless release", {oc[0].latched, oc[0].reattempt_readback}, 8'h0);
		wait_idle(n);
		tick(2);
		chk("endless on", oc[0].chan_on, 8'h1);
		chk("lamp clears", 8'(clr_cnt), 8'd17);
		cfg[0].retry_endless <= 1'b0;
		// fail-safe entry and sleep exit each clear the count
		for (int k = 0; k < 2; k++) begin
			fault();
			wait_idle(n);
			tick(2);
			chk("count one", oc[0].reattempt_readback, 8'h1);
			@(posedge i_clk_sys);
			fs <= (k == 0);
			se <= (k == 1);
			@(posedge i_clk_sys);
			fs <= 1'b0;
			se <= 1'b0;
			tick(2);
			chk("count cleared", oc[0].reattempt_readback, 8'h0);
		end
		$display("retry tests done");
		// mismatched select disables retry, fault latches, delatch turns on
		cfg[0].retry_select <= 1'b1;
		fault();
		tick(1);
		chk("latch at once", {oc[0].latched, oc[0].retry_active}, 8'h2);
		@(posedge i_clk_sys);
		ch[0].delatch <= 1'b1;
		@(posedge i_clk_sys);
		ch[0].delatch <= 1'b0;
		tick(1);
		chk("delatched", {oc[0].latched, oc[0].chan_on}, 8'h1);
		// motor profile: the duration clear waits for an over-current free period
		cfg[0].load_type_select <= 1'b1;
		fault();
		wait_idle(n);
		tick(2);
		chk("motor held", 8'(clr_cnt), 8'd19);
		@(posedge i_clk_sys);
		ch[0].oc_free_period_end <= 1'b1;
		@(posedge i_clk_sys);
		ch[0].oc_free_period_end <= 1'b0;
		tick(2);
		chk("motor clear", 8'(clr_cnt), 8'd20);
		$display("latch tests done");
		// off-state short, off-state open load, and a disabled check
		ch[0].switch_request <= 1'b0;
		tick(3);
		for (int k = 0; k < 3; k++) begin
			ch[0].supply_short_raw <= (k != 1);
			ch[0].open_load_dark_raw <= (k == 1);
			cfg[0].supply_short_disable <= (k == 2);
			tick(2);
			chk("diag set", {oc[0].short_to_supply, oc[0].open_load_dark},
				8'({k == 0, k == 1}));
			chk("pin live", {oc[0].chan_on, pin_n}, 8'(k == 2));
			ch[0].supply_short_raw <= 1'b0;
			ch[0].open_load_dark_raw <= 1'b0;
			tick(2);
			chk("diag held", {oc[0].short_to_supply, oc[0].open_load_dark, pin_n},
				8'({k == 0, k == 1, 1'b1}));
			read();
			chk("diag read", {oc[0].short_to_supply, oc[0].open_load_dark}, 8'h0);
		end
		cfg[0].supply_short_disable <= 1'b0;
		// a fault in the same cycle as the read survives it
		rd_req <= 1'b1;
		@(posedge i_clk_sys);
		rd_req <= 1'b0;
		ch[0].supply_short_raw <= 1'b1;
		@(posedge i_clk_sys);
		ch[0].supply_short_raw <= 1'b0;
		tick(2);
		chk("set wins", oc[0].short_to_supply, 8'h1);
		read();
		// on-state open load in the high ratio
		ch[0].switch_request <= 1'b1;
		tick(3);
		ch[0].open_load_lit_raw <= 1'b1;
		tick(2);
		chk("lit set", {oc[0].open_load_lit, oc[0].chan_on, pin_n}, 8'h6);
		read();
		chk("lit kept on read", oc[0].open_load_lit, 8'h1);
		ch[0].open_load_lit_raw <= 1'b0;
		tick(2);
		chk("lit pin back", {oc[0].open_load_lit, pin_n}, 8'h3);
		read();
		chk("lit cleared on", oc[0].open_load_lit, 8'h0);
		ch[0].open_load_lit_raw <= 1'b1;
		tick(2);
		ch[0].switch_request <= 1'b0;
		tick(3);
		read();
		chk("lit cleared off", oc[0].open_load_lit, 8'h0);
		// low sense ratio: checks only at turn-off, a clear needs a clean check first
		cfg[0].low_sense_ratio <= 1'b1;
		cfg[0].fast_slew <= 1'b1;
		toff();
		chk("low check set", {oc[0].open_load_lit, pin_n}, 8'h2);
		read();
		chk("low read kept", oc[0].open_load_lit, 8'h1);
		ch[0].open_load_lit_raw <= 1'b0;
		toff();
		chk("low clean", {oc[0].open_load_lit, pin_n}, 8'h3);
		read();
		chk("low read clears", oc[0].open_load_lit, 8'h0);
		// internal pwm: a turn-off too soon after the last check is skipped
		cfg[0].internal_pwm <= 1'b1;
		ch[0].open_load_lit_raw <= 1'b1;
		toff();
		chk("pwm too soon", oc[0].open_load_lit, 8'h0);
		tick(12);
		toff();
		chk("pwm check", oc[0].open_load_lit, 8'h1);
		chk("chan1 idle", 8'(|oc[1]), 8'h0);
		$display("diagnostic tests done");
		conclude();
	end
endmodule
